// [src/over_voltage_monitor_ctrl.v]
// Over-voltage monitor control: registers, debounce, interrupt, analog ctl
//
// Functional notes
// - An over-voltage event raises the interrupt only when enabled.
// - Comparator checks sense input against an 8-bit DAC threshold.
// - Protect enable 0 powers down comparator and DAC, 1 powers up.
// - Hysteresis bit is forwarded statically to the comparator.
// - Reference select picks supply (0) or external ref pin (1).
// - Debounce field picks none, 8, 16 or 32 stable clocks.
// - Read-only result bit shows comparator output; writes ignored.
// - Mode bit selects normal (0) or offset calibration (1).
// - Calibration ref select takes negative (0) or positive (1) input.
// - Five-bit trim drives offset adjust, resets to 10000.
// - Eight-bit threshold code, reset zero, drives the DAC.
// - Unimplemented config bits read 0; implemented reset to 0.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`include "ovp_regs.vh"
`default_nettype none
module over_voltage_monitor_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire [`OVP_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`OVP_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire comparator_out,
  output reg protect_enable,
  output reg hysteresis_enable,
  output reg dac_ref_select,
  output reg calibration_mode,
  output reg calibration_ref_select,
  output reg [4:0] offset_trim,
  output reg [7:0] dac_code,
  output reg irq
);
  // ========================================================================
  // Registers
  reg [7:0] cfg_r;
  reg [7:0] cal_r;
  reg [7:0] thr_r;
  reg irq_sts_r;
  reg irq_mask_r;
  reg [`OVP_ADDR_W-1:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg aw_have_r;
  reg w_have_r;
  wire comparator_result;
  wire filt;
  wire rise;
  wire do_write;
  wire wr_cfg;
  wire wr_cal;
  wire wr_thr;
  wire wr_irq;
  wire irq_set;
  wire irq_clr;

  // ========================================================================
  // Comparator input crosses from the analog domain
  sync3 u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(comparator_out),
    .q(comparator_result)
  );

  // Filter is held off in calibration so trim sweeps cause no events
  debounce u_deb (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(cfg_r[`CFG_PROTECT_EN_BIT] & ~cal_r[`CAL_MODE_BIT]),
    .sel(cfg_r[`CFG_DEB_LSB+1:`CFG_DEB_LSB]),
    .raw(comparator_result),
    .filt(filt),
    .rise(rise)
  );

  // ========================================================================
  // Write channel: address and data accepted in either order
  assign do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_cfg = do_write & (awaddr_r == `OVP_ENABLE_CONFIG_OFS) &
                  wstrb_r[0];
  assign wr_cal = do_write & (awaddr_r == `OVP_COMPARE_CAL_OFS) & wstrb_r[0];
  assign wr_thr = do_write & (awaddr_r == `OVP_THRESHOLD_OFS) & wstrb_r[0];
  assign wr_irq = do_write & (awaddr_r == `OVP_IRQ_STATUS_OFS);
  assign irq_set = rise;
  assign irq_clr = wr_irq & wstrb_r[0] & wdata_r[`IRQ_STATUS_BIT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= {`OVP_ADDR_W{1'b0}};
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Register file
  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= `CFG_RESET;
      cal_r <= {3'h0, `CAL_TRIM_RESET};
      thr_r <= `THRESHOLD_RESET;
      irq_mask_r <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_r <= wdata_r[7:0] & `CFG_IMPL_MASK;
      end
      if (wr_cal) begin
        // Result bit is not storage; only mode, ref and trim take writes
        cal_r <= {1'b0, wdata_r[6:0]};
      end
      if (wr_thr) begin
        thr_r <= wdata_r[7:0];
      end
      if (wr_irq && wstrb_r[1]) begin
        irq_mask_r <= wdata_r[`IRQ_MASK_BIT];
      end
    end
  end

  // Set wins over a simultaneous write-one clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_r <= 1'b0;
    end else if (irq_set) begin
      irq_sts_r <= 1'b1;
    end else if (irq_clr) begin
      irq_sts_r <= 1'b0;
    end
  end

  // ========================================================================
  // Read channel: one cycle to data after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `OVP_ENABLE_CONFIG_OFS: begin
            s_axi_rdata <= {24'h000000, cfg_r & `CFG_IMPL_MASK};
          end
          `OVP_COMPARE_CAL_OFS: begin
            // Live comparator level, not the filtered one
            s_axi_rdata <= {24'h000000, comparator_result,
                            cal_r[6:0]};
          end
          `OVP_THRESHOLD_OFS: begin
            s_axi_rdata <= {24'h000000, thr_r};
          end
          `OVP_IRQ_STATUS_OFS: begin
            s_axi_rdata <= {23'h000000, irq_mask_r, 6'h00, filt,
                            irq_sts_r};
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Analog controls and interrupt, all registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      protect_enable <= 1'b0;
      hysteresis_enable <= 1'b0;
      dac_ref_select <= 1'b0;
      calibration_mode <= 1'b0;
      calibration_ref_select <= 1'b0;
      offset_trim <= `CAL_TRIM_RESET;
      dac_code <= `THRESHOLD_RESET;
      irq <= 1'b0;
    end else begin
      protect_enable <= cfg_r[`CFG_PROTECT_EN_BIT];
      hysteresis_enable <= cfg_r[`CFG_HYST_BIT];
      dac_ref_select <= cfg_r[`CFG_REF_SEL_BIT];
      calibration_mode <= cal_r[`CAL_MODE_BIT];
      calibration_ref_select <= cal_r[`CAL_REF_BIT];
      offset_trim <= cal_r[4:0];
      dac_code <= thr_r;
      irq <= irq_sts_r & irq_mask_r;
    end
  end
endmodule // over_voltage_monitor_ctrl
`default_nettype wire

// [src/ovp_regs.vh]
// Register offsets, field positions, reset values and timing counts
`ifndef OVP_REGS_VH
`define OVP_REGS_VH
// ==========================================================================
// Offsets (byte addresses)
`define OVP_ENABLE_CONFIG_OFS 4'h0
`define OVP_COMPARE_CAL_OFS 4'h4
`define OVP_THRESHOLD_OFS 4'h8
`define OVP_IRQ_STATUS_OFS 4'hc
`define OVP_ADDR_W 4
// ==========================================================================
// Enable/configuration fields
`define CFG_PROTECT_EN_BIT 5
`define CFG_HYST_BIT 4
`define CFG_REF_SEL_BIT 2
`define CFG_DEB_LSB 0
`define CFG_IMPL_MASK 8'h37
`define CFG_RESET 8'h00
// ==========================================================================
// Compare/calibration fields
`define CAL_RESULT_BIT 7
`define CAL_MODE_BIT 6
`define CAL_REF_BIT 5
`define CAL_TRIM_RESET 5'h10
// ==========================================================================
// Interrupt register: status in bit 0, mask in bit 8
`define IRQ_STATUS_BIT 0
`define IRQ_MASK_BIT 8
// ==========================================================================
// Debounce lengths in system clocks
`define DEB_CYCLES_1 6'h08
`define DEB_CYCLES_2 6'h10
`define DEB_CYCLES_3 6'h20
`define THRESHOLD_RESET 8'h00
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [src/sync3.v]
// Three-stage synchroniser with agreement of the last two stages
`default_nettype none
module sync3 (
  input wire aclk,
  input wire aresetn,
  input wire d,
  output reg q
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // ========================================================================
  // Second stage only reads the first, avoiding metastable fan-out
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q <= s3_r;
      end
    end
  end
endmodule // sync3
`default_nettype wire

// [src/debounce.v]
// Comparator debounce filter with selectable stable length
`include "ovp_regs.vh"
`default_nettype none
module debounce (
  input wire aclk,
  input wire aresetn,
  input wire enable,
  input wire [1:0] sel,
  input wire raw,
  output reg filt,
  output reg rise
);
  reg [5:0] cnt_r;
  reg [5:0] len;
  always @* begin
    case (sel)
      2'h1: len = `DEB_CYCLES_1;
      2'h2: len = `DEB_CYCLES_2;
      2'h3: len = `DEB_CYCLES_3;
      default: len = 6'h00;
    endcase
  end
  // ========================================================================
  // Filtered state moves only after the raw level stayed put long enough
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 6'h00;
      filt <= 1'b0;
      rise <= 1'b0;
    end else if (!enable) begin
      cnt_r <= 6'h00;
      filt <= 1'b0;
      rise <= 1'b0;
    end else begin
      rise <= 1'b0;
      if (raw == filt) begin
        cnt_r <= 6'h00;
      end else if (cnt_r + 6'h01 >= len) begin
        cnt_r <= 6'h00;
        filt <= raw;
        rise <= raw;
      end else begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end
endmodule // debounce
`default_nettype wire

// [test/ovp_props.sv]
// Port assertions for the over-voltage monitor control
`default_nettype none
module ovp_props (
  input wire logic aclk, aresetn,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_arvalid,
  input wire logic s_axi_arready, s_axi_rvalid, protect_enable, irq,
  input wire logic [4:0] offset_trim,
  input wire logic [7:0] dac_code
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken; s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready; endsequence
  sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  // Response comes two edges after both halves are taken
  wr_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("late write response");
  wr_busy_a: assert property (wr_taken |=>
    (!s_axi_awready && !s_axi_wready) [*2]) else $error("ready too early");
  rd_resp_a: assert property (rd_taken |=>
    s_axi_rvalid && !s_axi_arready) else $error("late read response");
  // Analog controls move only one edge after a write completes
  en_write_a: assert property ($changed(protect_enable) |->
    $past(s_axi_bvalid)) else $error("enable moved alone");
  trim_write_a: assert property ($changed(offset_trim) |->
    $past(s_axi_bvalid)) else $error("trim moved alone");
  dac_write_a: assert property ($changed(dac_code) |->
    $past(s_axi_bvalid)) else $error("threshold moved alone");
  // Status is sticky, so the line falls only after a clear or mask write
  irq_fall_a: assert property ($fell(irq) |-> $past(s_axi_bvalid))
    else $error("interrupt dropped alone");
  irq_rise_a: assert property ($rose(irq) |->
    $past(s_axi_bvalid) || $past(protect_enable, 2))
    else $error("interrupt without cause");
endmodule // ovp_props
bind over_voltage_monitor_ctrl ovp_props u_props (.*);
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the over-voltage monitor control
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  failures++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic cmp = 1'b0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, rd_d;
  logic [1:0] resp, rr_d;
  wire [1:0] rresp;
  wire awr, wrd, bv, arr, rv, irq, pe, he, rs, cm, cr;
  wire [1:0] bresp;
  wire [31:0] rdata;
  wire [4:0] trim;
  wire [7:0] dac;
  int failures = 0, n_checks = 0;
  // Response readies stay high: the master is always able to take answers
  over_voltage_monitor_ctrl u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .comparator_out(cmp), .protect_enable(pe),
    .hysteresis_enable(he), .dac_ref_select(rs), .calibration_mode(cm),
    .calibration_ref_select(cr), .offset_trim(trim), .dac_code(dac),
    .irq(irq));
  always #50 aclk = ~aclk;
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv && ++n < 50);
    resp = bresp;
    if (n >= 50) failures++;
  endtask
  task automatic rd(input logic [3:0] a);
    int n = 0;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv && ++n < 50);
    rd_d = rdata;
    rr_d = rresp;
    if (n >= 50) failures++;
  endtask
  task automatic t_regs;
    `CHK("rst_pins", 18'h01000, {pe, he, rs, cm, cr, trim, dac})
    rd(4'h4);
    `CHK("cal_rst", 32'h10, rd_d)
    wr(4'h0, 32'hff);
    rd(4'h0);
    `CHK("cfg_rb", 32'h37, rd_d)
    `CHK("cfg_pins", 3'h7, {pe, he, rs})
    cmp <= 1'b1;
    // Let the comparator level clear the synchroniser first
    repeat (4) @(posedge aclk);
    wr(4'h4, 32'h7f);
    rd(4'h4);
    `CHK("cal_rb", 32'hff, rd_d)
    `CHK("cal_pins", 7'h7f, {cm, cr, trim})
    wr(4'h4, 32'h80);
    rd(4'h4);
    `CHK("result_ro", 32'h80, rd_d)
    cmp <= 1'b0;
    wr(4'h8, 32'ha5);
    rd(4'h8);
    `CHK("thr_rb", 32'ha5, rd_d)
    `CHK("dac_pin", 8'ha5, dac)
    wr(4'h2, 32'h0);
    `CHK("unaligned", 2'h2, resp)
    rd(4'h1);
    `CHK("unmapped", 2'h2, rr_d)
  endtask
  task automatic t_cal;
    int up = 0, dn = 0;
    wr(4'h0, 32'h20);
    `CHK("cal_hyst", 1'b0, he)
    for (int t = 0; t < 32; t++) begin
      cmp <= (t >= 12);
      wr(4'h4, 32'h60 | t);
      repeat (2) @(posedge aclk);
      rd(4'h4);
      if (rd_d[7] && up == 0) up = t;
    end
    `CHK("cal_mode", 2'h3, {cm, cr})
    for (int t = 31; t >= 0; t--) begin
      cmp <= (t >= 20);
      wr(4'h4, 32'h60 | t);
      repeat (2) @(posedge aclk);
      rd(4'h4);
      if (!rd_d[7] && dn == 0) dn = t;
    end
    `CHK("cal_up", 12, up)
    `CHK("cal_dn", 19, dn)
    wr(4'h4, (up + dn) >> 1);
    repeat (2) @(posedge aclk);
    `CHK("cal_avg", 5'h0f, trim)
  endtask
  task automatic t_deb;
    int l, n;
    wr(4'hc, 32'h100);
    for (int s = 0; s < 4; s++) begin
      l = (s == 0) ? 1 : 4 << s;
      wr(4'h0, 32'h20 | s);
      // A pulse two clocks short of the window must be filtered away
      if (s > 0) begin
        cmp <= 1'b1;
        repeat (l - 2) @(posedge aclk);
        cmp <= 1'b0;
        repeat (l + 8) @(posedge aclk);
        `CHK("short_pulse", 1'b0, irq)
      end
      cmp <= 1'b1;
      n = 0;
      while (irq !== 1'b1 && n < 80) begin
        @(posedge aclk);
        n++;
      end
      `CHK("deb_len", 1'b1, n >= l + 3 && n <= l + 9)
      cmp <= 1'b0;
      repeat (l + 8) @(posedge aclk);
      wr(4'hc, 32'h101);
      rd(4'hc);
      `CHK("w1c", 32'h100, rd_d)
      `CHK("irq_clr", 1'b0, irq)
    end
  endtask
  task automatic t_mask;
    wr(4'hc, 32'h0);
    cmp <= 1'b1;
    repeat (60) @(posedge aclk);
    `CHK("masked", 1'b0, irq)
    rd(4'hc);
    `CHK("pending", 32'h3, rd_d)
    wr(4'hc, 32'h100);
    repeat (2) @(posedge aclk);
    `CHK("unmasked", 1'b1, irq)
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_deb;
    t_mask;
    t_cal;
    give_verdict;
  end
  initial begin
    #1000000 failures++;
    give_verdict;
  end
endmodule // tb
`default_nettype wire
